// ---- design/gated_timer.sv ----
/*
 Gated 16-bit timer with clock select, prescaler, gate source, polarity,
 toggle and single-pulse gating, and a classic Wishbone register slave.
 Assumes pins are synchronous to clk_i, the system clock, except the external clock pin while bit 2 is clear.
*/
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
module gated_timer
   import timer_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        other_reset_i,
   input  wire logic        ce_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   input  wire logic        external_clock_pin_i,
   input  wire logic        crystal_in_pin_i,
   output logic             crystal_out_pin_o,
   output logic             low_power_osc_enable_o,
   input  wire logic        gate_pin_i,
   input  wire logic        timer0_overflow_i,
   input  wire logic        comparator_one_output_i,
   input  wire logic        comparator_two_output_i,
   output logic             overflow_flag_o,
   output logic             gate_event_flag_o,
   output logic [15:0]      count_o
);
   typedef struct packed {
      logic [7:0]  clock_ctrl;
      logic [7:0]  gate_ctrl;
      logic [15:0] count;
      logic        ovf;
      logic        gevt;
      logic [1:0]  inst_div;
      logic        sync1;
      logic        sync2;
      logic        sync_prev;
      logic        raw_prev;
      logic        xtal_prev;
      logic        xtal_out;
      logic        gpol_prev;
      logic        toggle_ff;
      logic        gt_prev;
      logic        gval_prev;
      logic        ack;
      logic [31:0] rdata;
   } timer_state_t;

   timer_state_t s;
   timer_state_t next_s;

   logic       req, commit, wr;
   logic       wr_clock, wr_gate, wr_low, wr_high, wr_flags;
   logic       on, osc_en, no_sync, ge, gpol_bit, gtm, gspm, go;
   logic [1:0] cs, ps, gss;
   logic       inst_tick, pin_tick, src_tick, pre_pulse, step;
   logic       gsrc, gpol, gt, gval, go_done_hw;
   logic       ovf_set, gevt_set;
   logic [7:0] rd_byte;

   assign on       = s.clock_ctrl[ON_BIT];
   assign osc_en   = s.clock_ctrl[OSCEN_BIT];
   assign no_sync  = s.clock_ctrl[NOSYNC_BIT];
   assign cs       = s.clock_ctrl[CS_POS +: 2];
   assign ps       = s.clock_ctrl[PS_POS +: 2];
   assign ge       = s.gate_ctrl[GE_BIT];
   assign gpol_bit = s.gate_ctrl[GPOL_BIT];
   assign gtm      = s.gate_ctrl[GTM_BIT];
   assign gspm     = s.gate_ctrl[GSPM_BIT];
   assign go       = s.gate_ctrl[GO_BIT];
   assign gss      = s.gate_ctrl[GSS_POS +: 2];

   // Write lands on the edge where the master sees ack
   assign req      = cyc_i && stb_i;
   assign commit   = req && s.ack;
   assign wr       = commit && we_i && sel_i[0];
   assign wr_clock = wr && (adr_i == ADR_CLOCK_CTRL);
   assign wr_gate  = wr && (adr_i == ADR_GATE_CTRL);
   assign wr_low   = wr && (adr_i == ADR_COUNT_LOW);
   assign wr_high  = wr && (adr_i == ADR_COUNT_HIGH);
   assign wr_flags = wr && (adr_i == ADR_FLAGS);

   // Counting clock sources
   assign inst_tick = (s.inst_div == INST_DIV_LAST);
   always_comb begin
      if (osc_en) begin
         pin_tick = crystal_in_pin_i && !s.xtal_prev;
      end else if (no_sync) begin
         pin_tick = external_clock_pin_i && !s.raw_prev;
      end else begin
         pin_tick = s.sync2 && !s.sync_prev;
      end
      case (cs)
         CS_INSTR:  src_tick = inst_tick;
         CS_SYSTEM: src_tick = 1'b1;
         CS_PIN:    src_tick = pin_tick;
         default:   src_tick = 1'b0;
      endcase
   end

   // Clearing on count writes keeps a stale partial divide out of the new count
   tick_prescaler #(
      .WIDTH (3)
   ) u_prescaler (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .clear_i (other_reset_i || wr_low || wr_high || !on),
      .tick_i  (src_tick),
      .ratio_i (ps),
      .pulse_o (pre_pulse)
   );

   // Gate path
   always_comb begin
      case (gss)
         GSS_PIN:    gsrc = gate_pin_i;
         GSS_T0_OVF: gsrc = timer0_overflow_i;
         GSS_COMP1:  gsrc = comparator_one_output_i;
         GSS_COMP2:  gsrc = comparator_two_output_i;
         default:    gsrc = gate_pin_i;
      endcase
   end
   assign gpol = gpol_bit ? gsrc : !gsrc;
   assign gt   = gtm ? s.toggle_ff : gpol;
   assign gval = gspm ? (go && gt) : gt;
   assign go_done_hw = gspm && go && s.gt_prev && !gt;
   assign step = pre_pulse && on && (!ge || gval);
   assign ovf_set  = step && (s.count == COUNT_MAX) && !wr_low && !wr_high;
   assign gevt_set = s.gval_prev && !gval;

   always_comb begin
      case (adr_i)
         ADR_CLOCK_CTRL: rd_byte = s.clock_ctrl & CLOCK_CTRL_MASK;
         ADR_GATE_CTRL:  rd_byte = {s.gate_ctrl[7:3], gval, s.gate_ctrl[1:0]};
         ADR_COUNT_LOW:  rd_byte = s.count[7:0];
         ADR_COUNT_HIGH: rd_byte = s.count[15:8];
         ADR_FLAGS:      rd_byte = {6'h00, s.gevt, s.ovf};
         default:        rd_byte = 8'h00;
      endcase
   end

   always_comb begin
      next_s = s;
      next_s.ack = req && !s.ack;
      if (req && !s.ack) begin
         next_s.rdata = {24'h000000, rd_byte};
      end
      next_s.inst_div  = s.inst_div + 2'h1;
      next_s.sync1     = external_clock_pin_i;
      next_s.sync2     = s.sync1;
      next_s.sync_prev = s.sync2;
      next_s.raw_prev  = external_clock_pin_i;
      next_s.xtal_prev = crystal_in_pin_i;
      next_s.xtal_out  = osc_en && !crystal_in_pin_i;
      next_s.gpol_prev = gpol;
      next_s.gt_prev   = gt;
      next_s.gval_prev = gval;
      if (wr_clock) begin
         next_s.clock_ctrl = dat_i[7:0] & CLOCK_CTRL_MASK;
      end
      // Software set of go wins over a completing pulse in the same cycle
      if (wr_gate) begin
         next_s.gate_ctrl = (dat_i[7:0] & GATE_CTRL_MASK) | {4'h0, dat_i[GO_BIT], 3'h0};
         if (go_done_hw && !dat_i[GO_BIT]) begin
            next_s.gate_ctrl[GO_BIT] = 1'b0;
         end
      end else if (go_done_hw) begin
         next_s.gate_ctrl[GO_BIT] = 1'b0;
      end
      if (!gtm || !on) begin
         next_s.toggle_ff = 1'b0;
      end else if (gpol && !s.gpol_prev) begin
         next_s.toggle_ff = !s.toggle_ff;
      end
      if (wr_low) begin
         next_s.count = {s.count[15:8], dat_i[7:0]};
      end else if (wr_high) begin
         next_s.count = {dat_i[7:0], s.count[7:0]};
      end else if (step) begin
         next_s.count = s.count + 16'h0001;
      end
      next_s.ovf  = (s.ovf && !(wr_flags && dat_i[OVF_BIT])) || ovf_set;
      next_s.gevt = (s.gevt && !(wr_flags && dat_i[GEVT_BIT])) || gevt_set;
      if (other_reset_i) begin
         next_s.inst_div  = 2'h0;
         next_s.toggle_ff = 1'b0;
         next_s.ack       = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
         s.clock_ctrl <= CLOCK_CTRL_RESET;
         s.gate_ctrl  <= GATE_CTRL_RESET;
         s.count      <= COUNT_RESET;
      end else if (ce_i) begin
         s <= next_s;
      end
   end

   assign dat_o                  = s.rdata;
   assign ack_o                  = s.ack;
   assign crystal_out_pin_o      = s.xtal_out;
   assign low_power_osc_enable_o = osc_en;
   assign overflow_flag_o        = s.ovf;
   assign gate_event_flag_o      = s.gevt;
   assign count_o                = s.count;

   unused_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && req && !s.ack && adr_i == ADR_CLOCK_CTRL) |=> (dat_o[1] == 1'b0))
      else $error("unimplemented control bit read nonzero");

   count_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && step && !wr_low && !wr_high) |=> (s.count == $past(s.count) + 16'h0001))
      else $error("count did not advance by one");

   count_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!on && !wr_low && !wr_high) |=> $stable(s.count))
      else $error("count moved while timer off");

   rollover_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && ovf_set) |=> (s.count == 16'h0000 && overflow_flag_o))
      else $error("rollover did not set overflow flag");

   gate_fall_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && s.gval_prev && !gval) |=> gate_event_flag_o)
      else $error("gate fall missed event flag");

   go_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && go_done_hw && !wr_gate) |=> (!s.gate_ctrl[GO_BIT] && !(step && ge && gspm)))
      else $error("single pulse did not complete");

   toggle_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && (!gtm || !on)) |=> (s.toggle_ff == 1'b0))
      else $error("toggle flop not cleared");

   reserved_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cs == 2'h3) |-> !src_tick)
      else $error("reserved clock source produced ticks");

   ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && ack_o) |=> !ack_o)
      else $error("ack held for two cycles");

   por_clear_a: assert property (@(posedge clk_i)
      rst_i |=> (s.clock_ctrl == 8'h00 && s.gate_ctrl == 8'h00))
      else $error("power-on reset left control bits set");

   src_system_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (cs == CS_SYSTEM) |-> src_tick)
      else $error("system clock source missed a tick");

   src_instr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && !other_reset_i && cs == CS_INSTR && src_tick) |=> (cs != CS_INSTR || !src_tick))
      else $error("instruction clock ticked twice in a row");

   osc_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && !osc_en) |=> !crystal_out_pin_o)
      else $error("crystal driven with oscillator off");

   off_no_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !on |-> !step)
      else $error("count step while timer off");

   gate_ignored_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (on && !ge) |-> (step == pre_pulse))
      else $error("gate held count with gate disabled");

   gate_blocks_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ge && !gval) |-> !step)
      else $error("count step with gate closed");

   polarity_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!gtm && !gspm) |-> (gval == (gsrc ~^ gpol_bit)))
      else $error("gate level ignores polarity");

   toggle_flip_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && !other_reset_i && on && gtm && gpol && !s.gpol_prev)
         |=> (s.toggle_ff != $past(s.toggle_ff)))
      else $error("toggle flop missed a gate rise");

   pulse_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (gspm && !go) |-> !gval)
      else $error("gate open with single pulse not armed");

   gval_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && req && !s.ack && adr_i == ADR_GATE_CTRL) |=> (dat_o[GVAL_BIT] == $past(gval)))
      else $error("gate value read back wrong");

   flag_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && !ovf_set && !overflow_flag_o) |=> !overflow_flag_o)
      else $error("overflow flag rose without rollover");

   count_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && wr_low) |=> (s.count[7:0] == $past(dat_i[7:0])))
      else $error("low count byte write lost");

   count_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && wr_high) |=> (s.count[15:8] == $past(dat_i[7:0])))
      else $error("high count byte write lost");

   ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && !other_reset_i && req && !ack_o) |=> ack_o)
      else $error("request not acknowledged");
endmodule

// ---- design/tick_prescaler.sv ----
/*
 Prescaler for the timer's selected input ticks: passes one tick in 1, 2, 4 or 8.
 Assumes ticks are one-cycle pulses in the clk_i domain.
*/
`timescale 1ns/1ns
module tick_prescaler
   import timer_pkg::*;
#(
   parameter int WIDTH = 3
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   input  wire logic       clear_i,
   input  wire logic       tick_i,
   input  wire logic [1:0] ratio_i,
   output logic            pulse_o
);
   typedef struct packed {
      logic [WIDTH-1:0] cnt;
   } pre_state_t;

   pre_state_t s;
   pre_state_t next_s;
   logic [WIDTH-1:0] last;

   always_comb begin
      last = WIDTH'((1 << ratio_i) - 1);
      next_s = s;
      pulse_o = tick_i && (s.cnt >= last);
      if (clear_i) begin
         next_s.cnt = '0;
      end else if (pulse_o) begin
         next_s.cnt = '0;
      end else if (tick_i) begin
         next_s.cnt = s.cnt + WIDTH'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else if (ce_i) begin
         s <= next_s;
      end
   end
endmodule

// ---- design/timer_pkg.sv ----
/*
 Constants of the gated 16-bit timer: register offsets, field positions,
 reset values and clock source and gate source codes.
 Assumes a classic Wishbone slave with 32-bit data, 8-bit registers in the low byte.
*/
// What this block does
// - Clock source field picks instruction, system, pin.
// - Pin source: pin edges, or crystal when enabled.
// - Prescale field divides input by 1,2,4,8.
// - Bit 3 enables the low-power oscillator.
// - Bit 2 clear synchronises external clock input.
// - Timer-on enables; off stops and clears toggle.
// - Gate enable ignored when off, else gates counting.
// - Gate polarity selects active gate level.
// - Toggle mode toggles on gate rise; off clears.
// - Single-pulse mode bit enables single-pulse gating.
// - Software arms go bit; hardware clears on completion.
// - Gate value bit reads live gate, read-only.
// - Gate source field picks pin, overflow, comparators.
// - Power-on reset zeroes bits; other resets keep.
// - Control bit 1 reads zero, ignores writes.
// - Count rolls FFFF to 0000, sets overflow flag.
// - Trailing pulse edge clears go, blocks counting.
// - Gate value falling edge sets gate event flag.
package timer_pkg;
   // Byte addresses
   localparam logic [7:0] ADR_CLOCK_CTRL = 8'h00;
   localparam logic [7:0] ADR_GATE_CTRL  = 8'h04;
   localparam logic [7:0] ADR_COUNT_LOW  = 8'h08;
   localparam logic [7:0] ADR_COUNT_HIGH = 8'h0C;
   localparam logic [7:0] ADR_FLAGS      = 8'h10;

   // Clock control fields
   localparam int CS_POS     = 6;
   localparam int PS_POS     = 4;
   localparam int OSCEN_BIT  = 3;
   localparam int NOSYNC_BIT = 2;
   localparam int ON_BIT     = 0;
   localparam logic [7:0] CLOCK_CTRL_MASK  = 8'hFD;
   localparam logic [7:0] CLOCK_CTRL_RESET = 8'h00;

   // Gate control fields
   localparam int GE_BIT   = 7;
   localparam int GPOL_BIT = 6;
   localparam int GTM_BIT  = 5;
   localparam int GSPM_BIT = 4;
   localparam int GO_BIT   = 3;
   localparam int GVAL_BIT = 2;
   localparam int GSS_POS  = 0;
   localparam logic [7:0] GATE_CTRL_MASK  = 8'hF3;
   localparam logic [7:0] GATE_CTRL_RESET = 8'h00;

   // Flag register fields, write one to clear
   localparam int OVF_BIT  = 0;
   localparam int GEVT_BIT = 1;

   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
   localparam logic [1:0]  INST_DIV_LAST = 2'h3;

   localparam logic [1:0] CS_INSTR    = 2'h0;
   localparam logic [1:0] CS_SYSTEM   = 2'h1;
   localparam logic [1:0] CS_PIN      = 2'h2;
   localparam logic [1:0] GSS_PIN     = 2'h0;
   localparam logic [1:0] GSS_T0_OVF  = 2'h1;
   localparam logic [1:0] GSS_COMP1   = 2'h2;
   localparam logic [1:0] GSS_COMP2   = 2'h3;
endpackage

// ---- sim/gated_16bit_timer_control_tb_top.sv ----
/*
 Self-checking bench for gated_timer: registers, clock rates, pin and crystal
 sources, gate sources and modes, flags, clock enable and both resets.
 Assumes timer_pkg and gated_timer are compiled first; one 20 MHz clock.
*/
`timescale 1ns/1ns
module gated_16bit_timer_control_tb_top;
   import timer_pkg::*;
   logic        clk_i = 0, rst_i = 1, other_reset_i = 0, ce_i = 1;
   logic        cyc_i = 0, stb_i = 0, we_i = 0;
   logic [7:0]  adr_i = 0;
   logic [3:0]  sel_i = 4'h1;
   logic [31:0] dat_i = 0;
   logic        external_clock_pin_i = 0, crystal_in_pin_i = 0, gate_pin_i = 0;
   logic        timer0_overflow_i = 0, comparator_one_output_i = 0, comparator_two_output_i = 0;
   logic [31:0] dat_o;
   logic        ack_o, crystal_out_pin_o, low_power_osc_enable_o;
   logic        overflow_flag_o, gate_event_flag_o;
   logic [15:0] count_o, c0;
   logic [7:0]  rd, d, g, mdl_ctrl;
   int          fail_count = 0, n_compared = 0, cycles = 0;

   gated_timer dut_u (.clk_i, .rst_i, .other_reset_i, .ce_i, .cyc_i, .stb_i, .we_i,
      .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .external_clock_pin_i, .crystal_in_pin_i,
      .crystal_out_pin_o, .low_power_osc_enable_o, .gate_pin_i, .timer0_overflow_i,
      .comparator_one_output_i, .comparator_two_output_i, .overflow_flag_o,
      .gate_event_flag_o, .count_o);

   always #25 clk_i = ~clk_i;

   task automatic complete_run();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Generous ceiling: whole sequence needs under two thousand cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         $display("mismatch at %0t: timeout", $time);
         complete_run();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Classic cycle: hold everything until ack is sampled high
   task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] v);
      @(posedge clk_i);
      cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= {24'h0, v};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      rd = dat_o[7:0];
      cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
      wb(a, 1'b0, 8'h00);
      check({8'h0, rd & m}, {8'h0, exp & m}, "register read");
   endtask

   // Settle first so pipeline latency drops out of the delta
   task automatic measure(input int w, input int exp);
      repeat (8) @(posedge clk_i);
      c0 = count_o;
      repeat (w) @(posedge clk_i);
      check(count_o - c0, exp[15:0], "count delta");
   endtask

   task automatic pulses(input int n, input bit xtal);
      repeat (n) begin
         @(posedge clk_i);
         if (xtal) crystal_in_pin_i <= 1'b1; else external_clock_pin_i <= 1'b1;
         repeat (2) @(posedge clk_i);
         crystal_in_pin_i <= 1'b0;
         external_clock_pin_i <= 1'b0;
         @(posedge clk_i);
      end
   endtask

   // Unselected sources carry the opposite level so a wrong pick shows
   task automatic gates(input int s, input logic lvl);
      @(posedge clk_i);
      gate_pin_i <= (s == 0) ? lvl : ~lvl;
      timer0_overflow_i <= (s == 1) ? lvl : ~lvl;
      comparator_one_output_i <= (s == 2) ? lvl : ~lvl;
      comparator_two_output_i <= (s == 3) ? lvl : ~lvl;
   endtask

   initial begin
      void'($urandom(32'h00bf7d3b));
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 5; i++) rdchk(i * 4, 8'h00, (i == 1) ? 8'hFB : 8'hFF);
      $display("test reset values done");
      repeat (4) begin
         d = $urandom;
         d[7] = d[7] & ~d[6];
         mdl_ctrl = d & CLOCK_CTRL_MASK;
         wb(ADR_CLOCK_CTRL, 1'b1, d);
         rdchk(ADR_CLOCK_CTRL, mdl_ctrl, 8'hFF);
         g = $urandom & 8'hEF;
         wb(ADR_GATE_CTRL, 1'b1, g);
         rdchk(ADR_GATE_CTRL, g, 8'hFB);
      end
      wb(8'h14, 1'b1, 8'hFF);
      rdchk(8'h14, 8'h00, 8'hFF);
      wb(ADR_CLOCK_CTRL, 1'b1, 8'h00);
      d = $urandom;
      g = $urandom;
      wb(ADR_COUNT_LOW, 1'b1, d);
      wb(ADR_COUNT_HIGH, 1'b1, g);
      rdchk(ADR_COUNT_LOW, d, 8'hFF);
      wb(ADR_CLOCK_CTRL, 1'b1, 8'h70);
      check(count_o, {g, d}, "count load");
      $display("test registers done");
      wb(ADR_GATE_CTRL, 1'b1, 8'h00);
      for (int cs = 0; cs < 2; cs++) begin
         for (int ps = 0; ps < 4; ps++) begin
            wb(ADR_CLOCK_CTRL, 1'b1, 8'((cs << CS_POS) | (ps << PS_POS) | 1));
            measure(64, 64 / (((cs == 0) ? 4 : 1) << ps));
         end
      end
      wb(ADR_CLOCK_CTRL, 1'b1, 8'hF1);
      measure(64, 0);
      $display("test clock rates done");
      for (int k = 0; k < 3; k++) begin
         wb(ADR_CLOCK_CTRL, 1'b1, 8'h81 | ((k == 2) ? 8'h08 : 8'h00) | ((k == 1) ? 8'h04 : 8'h00));
         repeat (2) @(posedge clk_i);
         check(low_power_osc_enable_o, (k == 2), "osc enable");
         check(crystal_out_pin_o, (k == 2), "crystal drive");
         c0 = count_o;
         pulses(5 + k, k == 2);
         repeat (8) @(posedge clk_i);
         check(count_o - c0, 16'(5 + k), "pin count");
      end
      $display("test pin sources done");
      wb(ADR_CLOCK_CTRL, 1'b1, 8'h41);
      for (int s = 0; s < 4; s++) begin
         for (int lvl = 0; lvl < 2; lvl++) begin
            gates(s, lvl[0]);
            wb(ADR_GATE_CTRL, 1'b1, 8'(8'hC0 | s));
            measure(32, lvl * 32);
         end
      end
      gates(0, 1'b0);
      wb(ADR_GATE_CTRL, 1'b1, 8'h80);
      measure(32, 32);
      wb(ADR_GATE_CTRL, 1'b1, 8'h40);
      measure(32, 32);
      gates(0, 1'b1);
      // Clear the sticky flag so only the next fall can set it
      wb(ADR_FLAGS, 1'b1, 8'h02);
      rdchk(ADR_GATE_CTRL, 8'h04, 8'h04);
      gates(0, 1'b0);
      rdchk(ADR_GATE_CTRL, 8'h00, 8'h04);
      check(gate_event_flag_o, 1'b1, "gate event");
      wb(ADR_FLAGS, 1'b1, 8'h02);
      @(posedge clk_i);
      check(gate_event_flag_o, 1'b0, "gate event clear");
      $display("test gate sources done");
      wb(ADR_GATE_CTRL, 1'b1, 8'hE0);
      measure(32, 0);
      gates(0, 1'b1);
      gates(0, 1'b0);
      measure(32, 32);
      wb(ADR_CLOCK_CTRL, 1'b1, 8'h40);
      wb(ADR_CLOCK_CTRL, 1'b1, 8'h41);
      measure(32, 0);
      wb(ADR_GATE_CTRL, 1'b1, 8'hD8);
      measure(16, 0);
      rdchk(ADR_GATE_CTRL, 8'h08, 8'h08);
      for (int p = 0; p < 2; p++) begin
         c0 = count_o;
         gates(0, 1'b1);
         repeat (10) @(posedge clk_i);
         gates(0, 1'b0);
         repeat (8) @(posedge clk_i);
         d = 8'(count_o - c0);
         check((p == 0) ? (d >= 9 && d <= 11) : (d == 0), 1'b1, "single pulse");
         rdchk(ADR_GATE_CTRL, 8'h00, 8'h08);
      end
      $display("test gate modes done");
      wb(ADR_CLOCK_CTRL, 1'b1, 8'h00);
      wb(ADR_GATE_CTRL, 1'b1, 8'h00);
      wb(ADR_FLAGS, 1'b1, 8'h03);
      wb(ADR_COUNT_LOW, 1'b1, 8'hF0);
      wb(ADR_COUNT_HIGH, 1'b1, 8'hFF);
      check(overflow_flag_o, 1'b0, "overflow idle");
      wb(ADR_CLOCK_CTRL, 1'b1, 8'h41);
      repeat (30) @(posedge clk_i);
      check(overflow_flag_o, 1'b1, "overflow set");
      check(count_o < 16'h0040, 1'b1, "wrapped count");
      wb(ADR_FLAGS, 1'b1, 8'h01);
      @(posedge clk_i);
      check(overflow_flag_o, 1'b0, "overflow clear");
      ce_i <= 1'b0;
      @(posedge clk_i);
      c0 = count_o;
      repeat (10) @(posedge clk_i);
      check(count_o, c0, "frozen count");
      ce_i <= 1'b1;
      @(posedge clk_i);
      other_reset_i <= 1'b1;
      @(posedge clk_i);
      other_reset_i <= 1'b0;
      rdchk(ADR_CLOCK_CTRL, 8'h41, 8'hFF);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk(ADR_CLOCK_CTRL, 8'h00, 8'hFF);
      $display("test resets done");
      complete_run();
   end
endmodule
